/* core/pin_sync.v */
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to clk; no reset is needed.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 1
) (
  // Clock
  input  wire         clk,
  // Asynchronous inputs and synchronised outputs
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  genvar i;

  // One two-stage chain per bit; stage one feeds only stage two
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg stab_q;
      always @(posedge clk) begin
        meta_q <= din[i];
        stab_q <= meta_q;
      end
      assign dout[i] = stab_q;
    end
  endgenerate

endmodule // pin_sync

/* core/spi_cfg_map.vh */
/*
  Constants for the SPI configuration and identification register bank:
  register offsets, field positions, reset values and timing counts.
  Assumes inclusion by spi_cfg_regs.v only; holds definitions only.
*/
`ifndef SPI_CFG_MAP_VH
`define SPI_CFG_MAP_VH

// Register offsets (15-bit SPI address space)
`define OFS_IFACE_CFG      15'h0000
`define OFS_OPMODE         15'h0002
`define OFS_CLASS          15'h0003
`define OFS_FAMILY_LO      15'h0004
`define OFS_FAMILY_HI      15'h0005
`define OFS_MAKER_LO       15'h000C
`define OFS_MAKER_HI       15'h000D
`define OFS_STREAM_CTL     15'h0010

// Reset values
`define RST_IFACE_CFG      8'h30
`define RST_OPMODE         8'h00
`define RST_CLASS_HI       4'h0
`define RST_STREAM_CTL     8'h00

// Field positions
`define BIT_SOFT_RESET     7
`define BIT_STEP_UP        5
`define BIT_SEP_OUT        4
`define BIT_ADDR_FREEZE    0

// Operating mode codes
`define MODE_NORMAL        2'h0
`define MODE_POWER_DOWN    2'h3

// Frame layout
`define HDR_BITS           16

// Chip reset duration after a software reset
`define SOFT_RST_NS        750
`define CLK_PERIOD_NS      8
`define SOFT_RST_CYC       (`SOFT_RST_NS / `CLK_PERIOD_NS)

`endif

/* core/spi_cfg_regs.v */
/*
  SPI slave holding the converter's interface configuration, operating
  mode, identification and streaming address registers.
  Assumes SPI mode 0 from an external host, MSB first: one R/W bit
  (1 = read), 15 address bits, then streamed data bytes. SCLK must be
  no faster than CORE_CLK / 8, as pins are oversampled.
*/
// How it works
// - Soft reset bit resets all registers, self-clears
// - Step-up bit 1 increments, 0 decrements address
// - Separate-output flag reads 1; read data on SDO
// - Mode 0 normal, 3 power down, else reserved
// - Class code fixed read-only in low nibble
// - Family code fixed read-only sixteen bits
// - Maker code fixed read-only sixteen bits
// - Freeze bit holds address during streaming
`timescale 1ns/1ps
`include "spi_cfg_map.vh"
module spi_cfg_regs #(
  parameter [3:0]  CLASS_CODE  = 4'hA,      // Arbitrary value
  parameter [15:0] FAMILY_CODE = 16'h1234,  // Arbitrary value
  parameter [15:0] MAKER_CODE  = 16'h5A5A   // Arbitrary value
) (
  // Clock and reset
  input  wire       CORE_CLK,
  input  wire       RST,
  // SPI pins
  input  wire       SPI_CS_N,
  input  wire       SPI_SCLK,
  input  wire       SPI_SDI,
  output wire       SPI_SDO,
  output wire       SPI_SDO_OE,
  // Device control
  output wire       CHIP_RESET,
  output wire [1:0] OP_MODE,
  output wire       MODE_NORMAL,
  output wire       POWER_DOWN
);

  // Synchronised pins
  wire       cs_n_s;
  wire       sclk_s;
  wire       sdi_s;
  reg        sclk_prev_q;
  wire       rise;
  wire       fall;

  // Frame engine state
  reg [15:0] sh_q;
  reg [3:0]  cnt_q;
  reg        in_data_q;
  reg        rd_q;
  reg [14:0] addr_q;
  reg [7:0]  tx_q;
  reg        sdo_q;
  reg        sdo_oe_q;
  reg        wr_stb_q;
  reg [14:0] wr_addr_q;
  reg [7:0]  wr_data_q;

  // Registers
  reg [7:0]  iface_q;
  reg [7:0]  opmode_q;
  reg [3:0]  class_hi_q;
  reg [7:0]  stream_q;
  reg [6:0]  rst_cnt_q;
  reg        chip_rst_q;
  wire       soft_go;
  wire       reg_rst;
  reg [15:0] sh_d;

  // Timing counts, cut on purpose to the widths of the counters using them
  wire [31:0] hdr_last = `HDR_BITS - 1;
  wire [31:0] rst_len  = `SOFT_RST_CYC;

  pin_sync #(
    .W (3)
  ) u_sync (
    .clk  (CORE_CLK),
    .din  ({SPI_CS_N, SPI_SCLK, SPI_SDI}),
    .dout ({cs_n_s, sclk_s, sdi_s})
  );

  // Read decode; unmapped addresses return zero
  function [7:0] rd_byte;
    input [14:0] a;
    begin
      case (a)
        `OFS_IFACE_CFG:  rd_byte = {1'b0, iface_q[6:5], 1'b1, iface_q[3:0]};
        `OFS_OPMODE:     rd_byte = opmode_q;
        `OFS_CLASS:      rd_byte = {class_hi_q, CLASS_CODE};
        `OFS_FAMILY_LO:  rd_byte = FAMILY_CODE[7:0];
        `OFS_FAMILY_HI:  rd_byte = FAMILY_CODE[15:8];
        `OFS_MAKER_LO:   rd_byte = MAKER_CODE[7:0];
        `OFS_MAKER_HI:   rd_byte = MAKER_CODE[15:8];
        `OFS_STREAM_CTL: rd_byte = stream_q;
        default:         rd_byte = 8'h00;
      endcase
    end
  endfunction

  // Address for the next streamed byte
  function [14:0] next_addr;
    input [14:0] a;
    begin
      if (stream_q[`BIT_ADDR_FREEZE])
        next_addr = a;
      else if (iface_q[`BIT_STEP_UP])
        next_addr = a + 15'h0001;
      else
        next_addr = a - 15'h0001;
    end
  endfunction

  // Edge detect on the stable synchronised clock
  always @(posedge CORE_CLK) begin
    if (RST)
      sclk_prev_q <= 1'b0;
    else
      sclk_prev_q <= sclk_s;
  end
  assign rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign fall = ~sclk_s & sclk_prev_q & ~cs_n_s;

  // Next shift value
  always @* begin
    sh_d = {sh_q[14:0], sdi_s};
  end

  // Frame engine: header capture, streaming, read data and write strobes
  always @(posedge CORE_CLK) begin
    if (RST || cs_n_s) begin
      sh_q      <= 16'h0000;
      cnt_q     <= 4'h0;
      in_data_q <= 1'b0;
      rd_q      <= 1'b0;
      addr_q    <= 15'h0000;
      tx_q      <= 8'h00;
      sdo_q     <= 1'b0;
      sdo_oe_q  <= 1'b0;
      wr_stb_q  <= 1'b0;
      wr_addr_q <= 15'h0000;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (rise) begin
        sh_q  <= sh_d;
        cnt_q <= cnt_q + 4'h1;
        if (!in_data_q) begin
          if (cnt_q == hdr_last[3:0]) begin
            in_data_q <= 1'b1;
            cnt_q     <= 4'h0;
            rd_q      <= sh_d[15];
            addr_q    <= sh_d[14:0];
            tx_q      <= rd_byte(sh_d[14:0]);
            sdo_oe_q  <= sh_d[15];
          end
        end else if (cnt_q[2:0] == 3'h7) begin
          addr_q <= next_addr(addr_q);
          if (rd_q)
            tx_q <= rd_byte(next_addr(addr_q));
          else begin
            wr_stb_q  <= 1'b1;
            wr_addr_q <= addr_q;
            wr_data_q <= sh_d[7:0];
          end
        end
      end else if (fall && in_data_q && rd_q) begin
        // Read data leaves on the dedicated output only
        sdo_q <= tx_q[7];
        tx_q  <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // Software reset request and the register reset it drives
  assign soft_go = wr_stb_q && (wr_addr_q == `OFS_IFACE_CFG) && wr_data_q[`BIT_SOFT_RESET];
  assign reg_rst = RST | soft_go;

  // Register writes; read-only fields are not stored
  always @(posedge CORE_CLK) begin
    if (reg_rst) begin
      iface_q    <= `RST_IFACE_CFG;
      opmode_q   <= `RST_OPMODE;
      class_hi_q <= `RST_CLASS_HI;
      stream_q   <= `RST_STREAM_CTL;
    end else if (wr_stb_q) begin
      case (wr_addr_q)
        `OFS_IFACE_CFG:  iface_q    <= {1'b0, wr_data_q[6:5], 1'b1, wr_data_q[3:0]};
        `OFS_OPMODE:     opmode_q   <= wr_data_q;
        `OFS_CLASS:      class_hi_q <= wr_data_q[7:4];
        `OFS_STREAM_CTL: stream_q   <= wr_data_q;
        default:         iface_q    <= iface_q;
      endcase
    end
  end

  // Chip reset pulse held for the reset duration after a software reset
  always @(posedge CORE_CLK) begin
    if (RST) begin
      rst_cnt_q  <= 7'h00;
      chip_rst_q <= 1'b0;
    end else if (soft_go) begin
      rst_cnt_q  <= rst_len[6:0];
      chip_rst_q <= 1'b1;
    end else if (rst_cnt_q != 7'h00) begin
      rst_cnt_q  <= rst_cnt_q - 7'h01;
      chip_rst_q <= (rst_cnt_q != 7'h01);
    end
  end

  // Outputs
  assign SPI_SDO     = sdo_q;
  assign SPI_SDO_OE  = sdo_oe_q;
  assign CHIP_RESET  = chip_rst_q;
  assign OP_MODE     = opmode_q[1:0];
  assign MODE_NORMAL = (opmode_q[1:0] == `MODE_NORMAL);
  assign POWER_DOWN  = (opmode_q[1:0] == `MODE_POWER_DOWN);

endmodule // spi_cfg_regs

/* tb/spi_cfg_assertions.sv */
/* Checker on the register bank ports.
   Assumes one core clock and synchronous active-high RST. */
`timescale 1ns/1ps
module spi_cfg_checker (
  // Clock, reset and pins
  input wire logic       CORE_CLK, RST, SPI_CS_N, SPI_SCLK, SPI_SDI, SPI_SDO, SPI_SDO_OE,
  // Device control
  input wire logic       CHIP_RESET, MODE_NORMAL, POWER_DOWN,
  input wire logic [1:0] OP_MODE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Mode decode, chip reset timing and output enable
  chk_normal_decode: assert property (MODE_NORMAL == (OP_MODE == 2'h0))
    else $error("normal flag wrong");
  chk_pwrdn_decode: assert property (POWER_DOWN == (OP_MODE == 2'h3))
    else $error("power down flag wrong");
  chk_mode_idle: assert property (SPI_CS_N [*8] |-> $stable(OP_MODE))
    else $error("mode moved outside a frame");
  chk_reset_hold: assert property ($rose(CHIP_RESET) |-> CHIP_RESET [*8])
    else $error("chip reset too short");
  chk_reset_ends: assert property ($rose(CHIP_RESET) |-> ##90 CHIP_RESET ##[1:6] !CHIP_RESET)
    else $error("chip reset length wrong");
  chk_reset_mode: assert property ($rose(CHIP_RESET) |-> ##[0:3] OP_MODE == 2'h0)
    else $error("mode not cleared by chip reset");
  chk_oe_in_frame: assert property ($rose(SPI_SDO_OE) |-> !SPI_CS_N)
    else $error("output enabled outside frame");
  chk_oe_idle: assert property (SPI_CS_N [*6] |-> !SPI_SDO_OE)
    else $error("output left enabled");
  // Serial output stays low while disabled and holds while the clock is high
  chk_sdo_quiet: assert property (!SPI_SDO_OE |-> !SPI_SDO)
    else $error("data out while output disabled");
  chk_sdo_hold: assert property (SPI_SCLK && $past(SPI_SCLK) |-> $stable(SPI_SDO))
    else $error("data out moved while clock high");
endmodule // spi_cfg_checker

bind spi_cfg_regs spi_cfg_checker chk (.CORE_CLK(CORE_CLK), .RST(RST), .SPI_CS_N(SPI_CS_N),
  .SPI_SCLK(SPI_SCLK), .SPI_SDI(SPI_SDI), .SPI_SDO(SPI_SDO), .SPI_SDO_OE(SPI_SDO_OE),
  .CHIP_RESET(CHIP_RESET), .MODE_NORMAL(MODE_NORMAL), .POWER_DOWN(POWER_DOWN),
  .OP_MODE(OP_MODE));

/* tb/spi_host_model.sv */
/* SPI host: mode 0 frames, MSB first.
   Assumes SCLK at most an eighth of the core clock. */
`timescale 1ns/1ps
module spi_host_model (
  // SPI pins
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  logic [7:0] wbuf [8];
  logic [7:0] rbuf [8];
  // Idle levels
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Header then n bytes; read data sampled on each rise
  task automatic frame(input logic rd, input logic [14:0] a, input int n);
    logic [15:0] h;
    h = {rd, a};
    cs_n = 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      sdi = (i < 16) ? h[15 - i] : wbuf[(i - 16) / 8][7 - i % 8];
      #40 sclk = 1'b1;
      if (i >= 16) rbuf[(i - 16) / 8][7 - i % 8] = sdo;
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    sdi = ~sdi; // Released line shows no stale value
    #100;
  endtask
endmodule // spi_host_model

/* tb/tb_top.sv */
/* Testbench: random and corner register traffic over SPI.
   Assumes host model and checker are compiled first. */
`timescale 1ns/1ps
module tb_top;
  localparam [3:0]  CC = 4'h6;     // Arbitrary value
  localparam [15:0] FC = 16'h2b3c; // Arbitrary value
  localparam [15:0] MC = 16'h7e19; // Arbitrary value
  logic        CORE_CLK = 1'b0;
  logic        RST = 1'b1;
  wire         cs_n, sclk, sdi, sdo, oe, crst;
  wire  [1:0]  mode;
  logic [7:0]  shd [32];
  logic [14:0] am [9] = '{0, 1, 2, 3, 4, 5, 12, 13, 16};
  logic [14:0] a;
  logic [7:0]  v;
  int          mismatches = 0;
  int          total_checks = 0;
  always #4 CORE_CLK = ~CORE_CLK;
  // An undriven output shows the inverse of its level, so a missing enable is seen
  spi_host_model host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(oe ? sdo : ~sdo));
  spi_cfg_regs #(.CLASS_CODE(CC), .FAMILY_CODE(FC), .MAKER_CODE(MC)) uut (
    .CORE_CLK(CORE_CLK), .RST(RST), .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_SDI(sdi),
    .SPI_SDO(sdo), .SPI_SDO_OE(oe), .CHIP_RESET(crst), .OP_MODE(mode), .MODE_NORMAL(),
    .POWER_DOWN());
  // Expected read value from the shadow copy
  function automatic logic [7:0] exp_reg(input logic [14:0] x);
    case (x)
      0: return {1'b0, shd[0][6:5], 1'b1, shd[0][3:0]};
      2, 16: return shd[x[4:0]];
      3: return {shd[3][7:4], CC};
      4: return FC[7:0];
      5: return FC[15:8];
      12: return MC[7:0];
      13: return MC[15:8];
      default: return 8'h00;
    endcase
  endfunction
  task chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task clr;
    foreach (shd[i]) shd[i] = 8'h00;
    shd[0] = 8'h30;
  endtask
  task wr(input logic [14:0] x, input logic [7:0] d);
    host.wbuf[0] = d;
    host.frame(1'b0, x, 1);
    shd[x[4:0]] = d;
  endtask
  // Streaming read, address stepped as the shadow says
  task rdchk(input logic [14:0] x, input int n);
    host.frame(1'b1, x, n);
    for (int i = 0; i < n; i++) begin
      chk(host.rbuf[i], exp_reg(x));
      x = shd[16][0] ? x : shd[0][5] ? x + 15'h0001 : x - 15'h0001;
    end
  endtask
  task give_verdict;
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hf8a4_1af9));
    clr;
    repeat (20) @(posedge CORE_CLK);
    #1 RST = 1'b0;
    repeat (4) @(posedge CORE_CLK);
    #1 rdchk(15'h0000, 6);
    rdchk(15'h000c, 2);
    for (int m = 0; m < 4; m++) begin
      v = 8'($urandom);
      wr(15'h0002, {v[7:2], m[1:0]});
      chk(mode, m[1:0]);
    end
    repeat (12) begin
      a = am[$urandom % 9];
      v = 8'($urandom);
      if (a == 0) v[7] = 1'b0;
      wr(a, v);
      rdchk(a, 3);
    end
    wr(15'h0000, 8'h00);
    wr(15'h0010, 8'h01);
    rdchk(15'h0004, 3);
    wr(15'h0010, 8'h00);
    rdchk(15'h0001, 3);
    wr(15'h0002, 8'h03);
    wr(15'h0000, 8'h80);
    chk(crst, 1'b1);
    #800;
    chk(crst, 1'b0);
    clr;
    chk(mode, 2'h0);
    rdchk(15'h0000, 1);
    rdchk(15'h0010, 1);
    give_verdict;
  end
  // Watchdog
  initial begin
    #400000;
    mismatches++;
    give_verdict;
  end
endmodule // tb_top
